// ---- logic/dvth_header_regs.sv ----
`timescale 1ns/1ps
// Functional notes
// - Control bit 28 lets host write CIP0 FN; cleared by reset.
// - Control bit 29 lets host write CIP0 DBS; cleared by reset.
// - Control bit 30 lets host write CIP0 SID; cleared by reset.
// - Control bit 31 lets host write header data length; cleared by reset.
// - Data length bits 0-15: host when enabled, else packetizer; reset 0008h.
// - Host loads tag bits 16-17; reset value 01.
// - Host loads channel, speed, sync; bus reset leaves them alone.
// - DBS bits 8-15 host-loaded when enabled, else 120.
// - SID bits 2-7 follow every physical register 0 transfer when not enabled.
// - FN bits 16-17 host-loaded when enabled, else 0.
// - Host loads QPC bits 18-20; default 0; bus reset leaves it.
// - SPH bit 21 auto set when timestamp included; zero for DV.
// - DBC bits 24-31 loaded and incremented by packetizer when not enabled.
// - FMT bits 2-7 host-loaded when enabled, else 00; stored reset 20h.
// - FDF: bit 8 frame system, 9-13 stream type, 14-15 zero, 16-31 SYT.
// - DV auto header takes frame system from CIP1 bit 8.
// - Alternate word clears on reset, drives packetizer in alternate mode.
// - Serial cycle-timer enable makes alternate word a shift register.
// - Delayed start holds bulky transmit until cycle timer equals alternate word.
// - Alternate word: quadlet count, header length, block increment.
// - Further enables QPC 23, FMT 25, DBC 26, SPH 27, cleared at reset.
module dvth_header_regs (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Microprocessor register port
  input wire logic [8:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_ack_o,
  // Packetizer
  input wire logic len_load_i,
  input wire logic [15:0] len_value_i,
  input wire logic dbc_load_i,
  input wire logic [7:0] dbc_value_i,
  input wire logic dbc_inc_i,
  input wire logic [7:0] dbc_step_i,
  input wire logic timestamp_included_i,
  input wire logic dv_mode_i,
  input wire logic dv_auto_header_i,
  // Physical layer
  input wire logic phy_reg0_valid_i,
  input wire logic [5:0] phy_node_id_i,
  // Cycle timer
  input wire logic ct_shift_i,
  input wire logic ct_serial_i,
  input wire logic [31:0] cycle_timer_i,
  input wire logic iso_start_req_i,
  // Results
  output dvth_pkg::dvth_hdr_t hdr_o,
  output dvth_pkg::dvth_alt_t alt_ctrl_o,
  output logic alt_mode_o,
  output logic frame_system_o,
  output logic iso_start_o,
  output logic ct_serial_o
);
  // ==========================================================
  // Decode
  function automatic logic hit(input logic [8:0] addr, input logic [8:0] off);
    hit = (addr == off);
  endfunction

  logic [31:0] pkt_ctrl;
  logic [15:0] data_length;
  logic [1:0] tag;
  logic [5:0] channel;
  logic [1:0] speed;
  logic [3:0] sync_bits;
  logic [5:0] source_id;
  logic [7:0] block_size;
  logic [1:0] fraction_number;
  logic [2:0] padding_count;
  logic source_header;
  logic [7:0] block_count;
  logic [1:0] cip1_top;
  logic [5:0] format;
  logic [23:0] format_dependent;
  logic [31:0] alt_word;
  logic alt_match;
  logic [31:0] eff_bus_hdr;
  logic [31:0] eff_cip0;
  logic [31:0] eff_cip1;
  logic [7:0] next_block_count;
  logic [31:0] next_rdata;

  logic wr_ctrl;
  logic wr_bus;
  logic wr_cip0;
  logic wr_cip1;
  logic wr_alt;
  assign wr_ctrl = reg_wr_i && hit(reg_addr_i, dvth_pkg::OFF_PKT_CTRL);
  assign wr_bus = reg_wr_i && hit(reg_addr_i, dvth_pkg::OFF_BUS_HDR);
  assign wr_cip0 = reg_wr_i && hit(reg_addr_i, dvth_pkg::OFF_CIP0);
  assign wr_cip1 = reg_wr_i && hit(reg_addr_i, dvth_pkg::OFF_CIP1);
  assign wr_alt = reg_wr_i && hit(reg_addr_i, dvth_pkg::OFF_ALT);

  logic len_we;
  logic sid_we;
  logic dbs_we;
  logic fn_we;
  logic sph_we;
  logic dbc_we;
  logic fmt_we;
  logic qpc_we;
  logic serial_ct_en;
  logic [1:0] delay_ctl;
  assign len_we = pkt_ctrl[dvth_pkg::CTL_LEN_WE];
  assign sid_we = pkt_ctrl[dvth_pkg::CTL_SID_WE];
  assign dbs_we = pkt_ctrl[dvth_pkg::CTL_DBS_WE];
  assign fn_we = pkt_ctrl[dvth_pkg::CTL_FN_WE];
  assign sph_we = pkt_ctrl[dvth_pkg::CTL_SPH_WE];
  assign dbc_we = pkt_ctrl[dvth_pkg::CTL_DBC_WE];
  assign fmt_we = pkt_ctrl[dvth_pkg::CTL_FMT_WE];
  assign qpc_we = pkt_ctrl[dvth_pkg::CTL_QPC_WE];
  assign serial_ct_en = pkt_ctrl[dvth_pkg::CTL_SERIAL_CT];
  assign delay_ctl = pkt_ctrl[dvth_pkg::CTL_DELAY_HI:dvth_pkg::CTL_DELAY_LO];
  assign alt_mode_o = pkt_ctrl[dvth_pkg::CTL_ALT_EN];

  // ==========================================================
  // Packetizer control
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pkt_ctrl <= dvth_pkg::CTL_RESET;
    end else if (wr_ctrl) begin
      pkt_ctrl <= reg_wdata_i & dvth_pkg::CTL_RW_MASK;
    end
  end

  // ==========================================================
  // Bus header quadlet; no bus reset input, so only reset, host writes and packetizer loads change it
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      data_length <= dvth_pkg::LEN_RESET;
    end else if (len_we) begin
      if (wr_bus) begin
        data_length <= reg_wdata_i[15:0];
      end
    end else if (len_load_i) begin
      data_length <= len_value_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tag <= dvth_pkg::TAG_RESET;
      channel <= '0;
      speed <= '0;
      sync_bits <= '0;
    end else if (wr_bus) begin
      tag <= reg_wdata_i[17:16];
      channel <= reg_wdata_i[23:18];
      speed <= reg_wdata_i[27:26];
      sync_bits <= reg_wdata_i[31:28];
    end
  end

  // ==========================================================
  // CIP header zero
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      source_id <= '0;
    end else if (sid_we) begin
      if (wr_cip0) begin
        source_id <= reg_wdata_i[7:2];
      end
    end else if (phy_reg0_valid_i) begin
      source_id <= phy_node_id_i;
    end
  end

  // Host values held aside so disabled DBS and FN fields keep their defaults and a disabled SPH is set automatically; a disabled QPC keeps its last write
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      block_size <= dvth_pkg::DBS_DEFAULT;
      fraction_number <= dvth_pkg::FN_DEFAULT;
      padding_count <= '0;
      source_header <= 1'b0;
    end else if (wr_cip0) begin
      if (dbs_we) begin
        block_size <= reg_wdata_i[15:8];
      end
      if (fn_we) begin
        fraction_number <= reg_wdata_i[17:16];
      end
      if (qpc_we) begin
        padding_count <= reg_wdata_i[20:18];
      end
      if (sph_we) begin
        source_header <= reg_wdata_i[21];
      end
    end
  end

  // Alternate mode supplies the increment in place of the packetizer's step
  always_comb begin
    next_block_count = block_count;
    if (dbc_load_i) begin
      next_block_count = dbc_value_i;
    end else if (dbc_inc_i) begin
      next_block_count = block_count + (alt_mode_o ? alt_word[31:24] : dbc_step_i);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      block_count <= '0;
    end else if (dbc_we) begin
      if (wr_cip0) begin
        block_count <= reg_wdata_i[31:24];
      end
    end else begin
      block_count <= next_block_count;
    end
  end

  // ==========================================================
  // CIP header one
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cip1_top <= dvth_pkg::CIP1_TOP_RESET;
      format <= dvth_pkg::FMT_RESET;
      format_dependent <= '0;
    end else if (wr_cip1) begin
      cip1_top <= reg_wdata_i[1:0];
      if (fmt_we) begin
        format <= reg_wdata_i[7:2];
      end
      format_dependent <= {reg_wdata_i[31:16], 2'b00, reg_wdata_i[13:8]};
    end
  end

  // ==========================================================
  // Alternate control word
  dvth_alt_word u_alt (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .host_wr_i(wr_alt),
    .wdata_i(reg_wdata_i),
    .shift_i(serial_ct_en && ct_shift_i),
    .serial_i(ct_serial_i),
    .cycle_timer_i(cycle_timer_i),
    .word_o(alt_word),
    .match_o(alt_match),
    .serial_o(ct_serial_o)
  );

  // Start gate is combinational so the match cycle is not lost
  assign iso_start_o = iso_start_req_i && ((delay_ctl == 2'b00) || alt_match);

  // ==========================================================
  // Effective header values
  always_comb begin
    eff_bus_hdr = {sync_bits, speed, 2'b00, channel, tag,
                   alt_mode_o ? alt_word[23:8] : data_length};
    eff_cip0 = {block_count, 2'b00,
                sph_we ? source_header : (timestamp_included_i && !dv_mode_i),
                padding_count,
                fn_we ? fraction_number : dvth_pkg::FN_DEFAULT,
                dbs_we ? block_size : dvth_pkg::DBS_DEFAULT,
                source_id, 2'b00};
    eff_cip1 = {format_dependent,
                fmt_we ? format : dvth_pkg::FMT_DEFAULT,
                cip1_top};
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      hdr_o <= '0;
      alt_ctrl_o <= '0;
      frame_system_o <= 1'b0;
    end else begin
      hdr_o <= '{bus_hdr: eff_bus_hdr, cip0: eff_cip0, cip1: eff_cip1};
      alt_ctrl_o <= '{quadlets: {4'h0, alt_word[7:0]}, length: alt_word[23:8],
                      increment: alt_word[31:24]};
      if (dv_mode_i && dv_auto_header_i) begin
        frame_system_o <= format_dependent[0];
      end
    end
  end

  // ==========================================================
  // Read path: CIP readback shows what the packetizer would send; bus header shows the stored length, not the alternate one
  always_comb begin
    next_rdata = '0;
    if (hit(reg_addr_i, dvth_pkg::OFF_PKT_CTRL)) begin
      next_rdata = pkt_ctrl;
    end else if (hit(reg_addr_i, dvth_pkg::OFF_BUS_HDR)) begin
      next_rdata = {sync_bits, speed, 2'b00, channel, tag, data_length};
    end else if (hit(reg_addr_i, dvth_pkg::OFF_CIP0)) begin
      next_rdata = eff_cip0;
    end else if (hit(reg_addr_i, dvth_pkg::OFF_CIP1)) begin
      next_rdata = eff_cip1;
    end else if (hit(reg_addr_i, dvth_pkg::OFF_ALT)) begin
      next_rdata = alt_word;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= '0;
      reg_ack_o <= 1'b0;
    end else begin
      reg_ack_o <= reg_wr_i || reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_len_host_only: assert property (
    (!len_we && !len_load_i) |=> $stable(data_length))
    else $error("data length changed without a load");
  a_len_reset_val: assert property (
    $rose(rst_n_i) |-> data_length == dvth_pkg::LEN_RESET && tag == dvth_pkg::TAG_RESET)
    else $error("header reset value wrong");
  a_dbs_default: assert property (
    !dbs_we |-> eff_cip0[15:8] == dvth_pkg::DBS_DEFAULT)
    else $error("block size default wrong");
  a_sid_follow: assert property (
    (!sid_we && phy_reg0_valid_i) |=> source_id == $past(phy_node_id_i))
    else $error("source id not updated");
  a_fn_default: assert property (
    !fn_we |-> eff_cip0[17:16] == dvth_pkg::FN_DEFAULT)
    else $error("fraction number default wrong");
  a_sph_dv_zero: assert property (
    (!sph_we && dv_mode_i) |-> !eff_cip0[21])
    else $error("source header set in DV");
  a_dbc_step: assert property (
    (!dbc_we && dbc_inc_i && !dbc_load_i && !alt_mode_o) ##1 !dbc_we |->
      block_count == 8'($past(block_count) + $past(dbc_step_i)))
    else $error("block count increment wrong");
  a_fmt_default: assert property (
    !fmt_we |-> eff_cip1[7:2] == dvth_pkg::FMT_DEFAULT)
    else $error("format default wrong");
  a_frame_sys: assert property (
    (dv_mode_i && dv_auto_header_i) |=> frame_system_o == $past(format_dependent[0]))
    else $error("frame system not taken");
  a_delay_gate: assert property (
    (delay_ctl != 2'b00 && cycle_timer_i != alt_word) |-> !iso_start_o)
    else $error("bulky start before match");
  a_alt_length: assert property (
    alt_mode_o ##1 alt_mode_o |-> hdr_o.bus_hdr[15:0] == $past(alt_word[23:8]))
    else $error("alternate length not used");
  a_shift_word: assert property (
    (serial_ct_en && ct_shift_i && !wr_alt) |=>
      alt_word == {$past(alt_word[30:0]), $past(ct_serial_i)})
    else $error("cycle timer shift wrong");

  c_host_len: cover property (len_we && wr_bus);
  c_sid_auto: cover property (!sid_we && phy_reg0_valid_i);
  c_delay_start: cover property (delay_ctl != 2'b00 && iso_start_o);
  c_alt_mode: cover property (alt_mode_o && dbc_inc_i);
endmodule // dvth_header_regs

// ---- logic/dvth_pkg.sv ----
package dvth_pkg;
  // ==========================================================
  // Register map
  localparam logic [8:0] OFF_PKT_CTRL = 9'h1C4;
  localparam logic [8:0] OFF_BUS_HDR = 9'h1C8;
  localparam logic [8:0] OFF_CIP0 = 9'h1CC;
  localparam logic [8:0] OFF_CIP1 = 9'h1D0;
  localparam logic [8:0] OFF_ALT = 9'h1E0;
  // ==========================================================
  // Packetizer control bit positions
  localparam int CTL_SERIAL_CT = 0;
  localparam int CTL_DELAY_LO = 16;
  localparam int CTL_DELAY_HI = 17;
  localparam int CTL_ALT_EN = 18;
  localparam int CTL_QPC_WE = 23;
  localparam int CTL_FMT_WE = 25;
  localparam int CTL_DBC_WE = 26;
  localparam int CTL_SPH_WE = 27;
  localparam int CTL_FN_WE = 28;
  localparam int CTL_DBS_WE = 29;
  localparam int CTL_SID_WE = 30;
  localparam int CTL_LEN_WE = 31;
  localparam logic [31:0] CTL_RW_MASK = 32'hFE870001;
  localparam logic [31:0] CTL_RESET = 32'h00000001;
  // ==========================================================
  // Field reset and default values
  localparam logic [15:0] LEN_RESET = 16'h0008;
  localparam logic [1:0] TAG_RESET = 2'h1;
  localparam logic [7:0] DBS_DEFAULT = 8'h78;
  localparam logic [1:0] FN_DEFAULT = 2'h0;
  localparam logic [5:0] FMT_RESET = 6'h20;
  localparam logic [5:0] FMT_DEFAULT = 6'h00;
  localparam logic [1:0] CIP1_TOP_RESET = 2'h1;
  localparam logic [31:0] ALT_RESET = 32'h00000000;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [31:0] bus_hdr;
    logic [31:0] cip0;
    logic [31:0] cip1;
  } dvth_hdr_t;

  typedef struct packed {
    logic [11:0] quadlets;
    logic [15:0] length;
    logic [7:0] increment;
  } dvth_alt_t;
endpackage

// ---- logic/dvth_alt_word.sv ----
`timescale 1ns/1ps
module dvth_alt_word (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Host side
  input wire logic host_wr_i,
  input wire logic [31:0] wdata_i,
  // Serial cycle timer
  input wire logic shift_i,
  input wire logic serial_i,
  input wire logic [31:0] cycle_timer_i,
  // Results
  output logic [31:0] word_o,
  output logic match_o,
  output logic serial_o
);
  // ==========================================================
  // Storage: host write beats a shift in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      word_o <= dvth_pkg::ALT_RESET;
    end else if (host_wr_i) begin
      word_o <= wdata_i;
    end else if (shift_i) begin
      word_o <= {word_o[30:0], serial_i};
    end
  end

  assign serial_o = word_o[31];
  assign match_o = (cycle_timer_i == word_o);
endmodule // dvth_alt_word

// ---- test/dvth_phy_model.sv ----
`timescale 1ns/1ps
// ==========================================
// Physical layer stand-in: register 0 transfers
module dvth_phy_model (
  // Clock
  input wire logic core_clk_i,
  // Transfer
  output logic reg0_valid_o,
  output logic [5:0] node_id_o
);
  initial begin
    reg0_valid_o = 1'b0;
    node_id_o = 6'h15;
  end
  // Id line flips after a transfer so no stale value survives
  task automatic send(input logic [5:0] id);
    @(posedge core_clk_i);
    #1;
    reg0_valid_o = 1'b1;
    node_id_o = id;
    @(posedge core_clk_i);
    #1;
    reg0_valid_o = 1'b0;
    node_id_o = ~id;
  endtask
endmodule // dvth_phy_model

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ack, len_ld = 1'b0, dbc_ld = 1'b0, dbc_inc = 1'b0;
  logic [8:0] addr = 9'h000;
  logic [31:0] wdata = 32'h0, rdata, ctv = 32'h0, q;
  logic [15:0] len_v = 16'h0;
  logic [7:0] dbc_v = 8'h0, dbc_st = 8'h0;
  logic ts = 1'b0, dvm = 1'b0, dva = 1'b0, pv, shift = 1'b0, ser = 1'b0, isoreq = 1'b0;
  logic altm, fs, iso, sero;
  logic [5:0] pid;
  dvth_pkg::dvth_hdr_t hdr;
  dvth_pkg::dvth_alt_t altc;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  always #20 clk = ~clk;
  dvth_phy_model phy (.core_clk_i(clk), .reg0_valid_o(pv), .node_id_o(pid));
  dvth_header_regs dut (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ack_o(ack), .len_load_i(len_ld), .len_value_i(len_v),
    .dbc_load_i(dbc_ld), .dbc_value_i(dbc_v), .dbc_inc_i(dbc_inc), .dbc_step_i(dbc_st),
    .timestamp_included_i(ts), .dv_mode_i(dvm), .dv_auto_header_i(dva), .phy_reg0_valid_i(pv),
    .phy_node_id_i(pid), .ct_shift_i(shift), .ct_serial_i(ser), .cycle_timer_i(ctv),
    .iso_start_req_i(isoreq), .hdr_o(hdr), .alt_ctrl_o(altc), .alt_mode_o(altm), .frame_system_o(fs),
    .iso_start_o(iso), .ct_serial_o(sero));
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wr = w;
    rd = !w;
    wdata = d;
    @(posedge clk);
    #1;
    wr = 1'b0;
    rd = 1'b0;
    q = rdata;
    chk(ack, 1'b1);
  endtask
  task automatic rdc(input logic [8:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    rdc(dvth_pkg::OFF_PKT_CTRL, 32'h00000001);
    rdc(dvth_pkg::OFF_BUS_HDR, 32'h00010008);
    rdc(dvth_pkg::OFF_CIP0, 32'h00007800);
    rdc(dvth_pkg::OFF_CIP1, 32'h00000001);
    rdc(dvth_pkg::OFF_ALT, 32'h00000000);
    chk(hdr.cip0, 32'h00007800);
    $display("test reset done");
  endtask
  task automatic t_cip0();
    acc(1'b1, dvth_pkg::OFF_CIP0, 32'hFFFFFFFF);
    rdc(dvth_pkg::OFF_CIP0, 32'h00007800);
    acc(1'b1, dvth_pkg::OFF_PKT_CTRL, 32'hFE800001);
    rdc(dvth_pkg::OFF_PKT_CTRL, 32'hFE800001);
    acc(1'b1, dvth_pkg::OFF_CIP0, 32'hFFFFFFFF);
    rdc(dvth_pkg::OFF_CIP0, 32'hFF3FFFFC);
    settle();
    chk(hdr.cip0, 32'hFF3FFFFC);
    acc(1'b1, dvth_pkg::OFF_PKT_CTRL, 32'h00000001);
    $display("test cip0 done");
  endtask
  task automatic t_auto();
    phy.send(6'h2A);
    settle();
    chk(hdr.cip0[7:2], 6'h2A);
    @(posedge clk);
    #1;
    dbc_ld = 1'b1;
    dbc_v = 8'h10;
    dbc_st = 8'h03;
    @(posedge clk);
    #1;
    dbc_ld = 1'b0;
    dbc_inc = 1'b1;
    @(posedge clk);
    #1;
    dbc_inc = 1'b0;
    settle();
    chk(hdr.cip0[31:24], 8'h13);
    ts = 1'b1;
    settle();
    chk(hdr.cip0[21], 1'b1);
    dvm = 1'b1;
    settle();
    chk(hdr.cip0[21], 1'b0);
    ts = 1'b0;
    dvm = 1'b0;
    $display("test auto done");
  endtask
  task automatic t_len();
    @(posedge clk);
    #1;
    len_ld = 1'b1;
    len_v = 16'h1234;
    @(posedge clk);
    #1;
    len_ld = 1'b0;
    acc(1'b1, dvth_pkg::OFF_BUS_HDR, 32'hFFFF5555);
    rdc(dvth_pkg::OFF_BUS_HDR, 32'hFCFF1234);
    acc(1'b1, dvth_pkg::OFF_PKT_CTRL, 32'h80000001);
    acc(1'b1, dvth_pkg::OFF_BUS_HDR, 32'h00005555);
    @(posedge clk);
    #1;
    len_ld = 1'b1;
    len_v = 16'h1111;
    @(posedge clk);
    #1;
    len_ld = 1'b0;
    rdc(dvth_pkg::OFF_BUS_HDR, 32'h00005555);
    settle();
    chk(hdr.bus_hdr, 32'h00005555);
    $display("test length done");
  endtask
  task automatic t_cip1();
    acc(1'b1, dvth_pkg::OFF_PKT_CTRL, 32'h00000001);
    acc(1'b1, dvth_pkg::OFF_CIP1, 32'hABCDFFFD);
    rdc(dvth_pkg::OFF_CIP1, 32'hABCD3F01);
    dvm = 1'b1;
    dva = 1'b1;
    settle();
    chk(fs, 1'b1);
    acc(1'b1, dvth_pkg::OFF_CIP1, 32'h00000001);
    settle();
    chk(fs, 1'b0);
    acc(1'b1, dvth_pkg::OFF_PKT_CTRL, 32'h02000001);
    // Stored power-on format shows once its enable is set
    rdc(dvth_pkg::OFF_CIP1, 32'h00000081);
    acc(1'b1, dvth_pkg::OFF_CIP1, 32'hABCD00FD);
    rdc(dvth_pkg::OFF_CIP1, 32'hABCD00FD);
    $display("test cip1 done");
  endtask
  task automatic t_alt();
    acc(1'b1, dvth_pkg::OFF_PKT_CTRL, 32'h00040001);
    acc(1'b1, dvth_pkg::OFF_ALT, 32'hAB1234CD);
    settle();
    chk(altc, {12'h0CD, 16'h1234, 8'hAB});
    chk(hdr.bus_hdr[15:0], 16'h1234);
    chk(altm, 1'b1);
    chk(sero, 1'b1);
    // Alternate increment replaces the packetizer step
    dbc_inc = 1'b1;
    @(posedge clk);
    #1;
    dbc_inc = 1'b0;
    settle();
    chk(hdr.cip0[31:24], 8'hBE);
    shift = 1'b1;
    @(posedge clk);
    #1;
    shift = 1'b0;
    rdc(dvth_pkg::OFF_ALT, 32'h5624699A);
    chk(sero, 1'b0);
    acc(1'b1, dvth_pkg::OFF_PKT_CTRL, 32'h00010001);
    // Gate is combinational, so look mid-cycle
    isoreq = 1'b1;
    @(negedge clk);
    chk(iso, 1'b0);
    @(posedge clk);
    #1;
    ctv = 32'h5624699A;
    @(negedge clk);
    chk(iso, 1'b1);
    @(posedge clk);
    #1;
    isoreq = 1'b0;
    acc(1'b1, 9'h1D4, 32'hFFFFFFFF);
    rdc(9'h1D4, 32'h00000000);
    $display("test alternate done");
  endtask
  task automatic t_soft_reset();
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rdc(dvth_pkg::OFF_PKT_CTRL, 32'h00000001);
    rdc(dvth_pkg::OFF_BUS_HDR, 32'h00010008);
    rdc(dvth_pkg::OFF_CIP0, 32'h00007800);
    rdc(dvth_pkg::OFF_ALT, 32'h00000000);
    $display("test soft reset done");
  endtask
  // ==========================================
  // Run control
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Ceiling well above the roughly 120 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_cip0();
    t_auto();
    t_len();
    t_cip1();
    t_alt();
    t_soft_reset();
    tally_and_finish();
  end
endmodule // tb_top
